/* design/pmec_map.svh */
// named widths, positions and reset values for the miss and exception control block
`ifndef PMEC_MAP_SVH
`define PMEC_MAP_SVH
`define PMEC_INSTR_W 32
`define PMEC_BUS_W 64
`define PMEC_HI_LANE 32
`define PMEC_REG_W 5
`define PMEC_LINE_INSTR 8
`define PMEC_REG_ZERO 5'h00
`define PMEC_SYNC_RST 1'h0
`endif

/* design/pmec_pipe_ctrl.sv */
// pipeline control for cache refills, uncached accesses and exception aborts
`timescale 1ns/1ps
`include "pmec_map.svh"
module pmec_pipe_ctrl #(
  parameter int LINE_INSTR = `PMEC_LINE_INSTR  // instructions held per refilled line
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire pmec_pkg::pmec_fetch_type fetch_in,
  input wire pmec_pkg::pmec_dec_type dec_in,
  input wire pmec_pkg::pmec_exe_type exe_in,
  input wire pmec_pkg::pmec_mem_type mem_in,
  input wire pmec_pkg::pmec_bus_rsp_type bus_in,
  input wire logic soft_reset_req,
  input wire logic wide_bus_1to1,
  input wire logic div_busy,
  output pmec_pkg::pmec_bus_req_type bus_out,
  output pmec_pkg::pmec_issue_type issue,
  output logic stall_fetch,
  output logic stall_exec,
  output pmec_pkg::pmec_flush_type flush,
  output logic div_kill
);

  localparam int PW = $clog2(LINE_INSTR) + 1;  // pointer width with wrap bit
  localparam int IW = PW - 1;                  // index width

  // the buffer pairs two instructions per beat, so an odd depth cannot be served
  initial begin
    if (LINE_INSTR < 2 || (LINE_INSTR & (LINE_INSTR - 1)) != 0) begin
      $error("LINE_INSTR must be a power of two, at least two");
    end
  end

  typedef enum logic [2:0] {IF_IDLE, IF_WAIT, IF_FILL, IF_DRAIN, IF_TARGET} pmec_ifill_type;
  typedef enum logic [1:0] {D_IDLE, D_WAIT, D_FILL} pmec_dfill_type;

  pmec_ifill_type istate;  // instruction refill progress
  pmec_ifill_type next_istate;
  pmec_dfill_type dstate;  // data refill progress
  pmec_dfill_type next_dstate;

  logic wide_meta;  // first stage of the bus mode synchroniser
  logic wide_sync;  // bus mode, safe to read
  logic stream_mode;  // latched at the start of each instruction fill
  logic cut;  // streaming stopped by a branch or exception
  logic i_uncached;  // pending fetch is single beat
  logic d_uncached;  // pending data access is single beat
  logic d_write;  // pending data access is an uncached store
  logic load_pending;  // a missed load still owes its data
  logic [`PMEC_REG_W-1:0] load_dest;  // register the missed load writes
  logic [PW-1:0] wr_ptr;  // next free buffer slot
  logic [PW-1:0] rd_ptr;  // next instruction to issue
  logic [`PMEC_INSTR_W-1:0] line_mem [LINE_INSTR];  // refilled instructions

  // the bus mode is a board strap, so it crosses two flops first
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wide_meta <= `PMEC_SYNC_RST;
      wide_sync <= `PMEC_SYNC_RST;
    end else begin
      wide_meta <= wide_bus_1to1;
      wide_sync <= wide_meta;
    end
  end

  // exception classification
  wire exc_e = exe_in.valid & (exe_in.debug_single_step_exc | exe_in.debug_instr_break_exc |
                               exe_in.fetch_address_error_exc | exe_in.fetch_translation_miss_exc);
  wire exc_m = mem_in.valid & mem_in.exc;
  wire fatal = soft_reset_req | bus_in.berr;
  wire take = fatal | exc_m | exc_e;
  // memory stage wins over execute: it holds the older instruction
  wire pmec_pkg::pmec_vec_type next_vec = soft_reset_req ? pmec_pkg::PMEC_VEC_RESET :
                                           bus_in.berr ? pmec_pkg::PMEC_VEC_BUSERR :
                                           exc_m ? pmec_pkg::PMEC_VEC_MSTAGE : pmec_pkg::PMEC_VEC_ESTAGE;

  // bus ownership decode
  wire granted = bus_out.req & bus_in.grant;
  wire grant_i = granted & (bus_out.kind == pmec_pkg::PMEC_BUS_IFETCH);
  wire grant_d = granted & (bus_out.kind != pmec_pkg::PMEC_BUS_IFETCH);
  wire beat_i = (istate == IF_FILL) & bus_in.beat;
  wire beat_d = (dstate == D_FILL) & bus_in.beat;
  wire last_i = beat_i & (bus_in.last | i_uncached);
  wire last_d = beat_d & (bus_in.last | d_uncached);

  // miss and uncached detection
  wire fetch_start = fetch_in.valid & (fetch_in.miss | fetch_in.uncached);
  wire load_start = mem_in.valid & mem_in.is_load & (mem_in.dmiss | mem_in.uncached);
  wire store_start = mem_in.valid & mem_in.is_store & mem_in.uncached;
  wire d_start = (load_start | store_start) & ~take;

  // issue decode: one entry a cycle from the line buffer
  wire buf_has = rd_ptr != wr_ptr;
  wire may_stream = (istate == IF_FILL) & stream_mode;
  wire stop_now = exe_in.valid & exe_in.is_branch & (istate == IF_FILL) & stream_mode;
  // while streaming a fill, the delay slot is already out when the branch executes, so nothing more leaves
  wire can_issue = (may_stream | (istate == IF_DRAIN)) & buf_has & ~cut & ~stop_now & ~stall_exec & ~take;

  // data refill sequence
  always_comb begin
    next_dstate = dstate;
    case (dstate)
      D_IDLE: begin
        if (d_start) begin
          next_dstate = D_WAIT;
        end
      end
      D_WAIT: begin
        if (grant_d) begin
          next_dstate = D_FILL;
        end
      end
      D_FILL: begin
        if (last_d) begin
          next_dstate = D_IDLE;  // ordinary end, only a soft reset or bus error stops it early
        end
      end
      default: begin
        next_dstate = D_IDLE;
      end
    endcase
    if (fatal) begin
      next_dstate = D_IDLE;
    end
  end

  // instruction refill sequence
  always_comb begin
    next_istate = istate;
    case (istate)
      IF_IDLE: begin
        if (fetch_start & ~take) begin
          next_istate = IF_WAIT;
        end
      end
      IF_WAIT: begin
        if (grant_i) begin
          next_istate = IF_FILL;
        end
      end
      IF_FILL: begin
        if (last_i) begin
          next_istate = (cut | stop_now) ? IF_TARGET : IF_DRAIN;
        end
      end
      IF_DRAIN: begin
        if (cut | take) begin
          next_istate = IF_TARGET;
        end else if (~buf_has) begin
          next_istate = IF_IDLE;
        end
      end
      IF_TARGET: begin
        if (fetch_start) begin
          next_istate = IF_WAIT;  // target itself missed
        end else if (fetch_in.valid) begin
          next_istate = IF_IDLE;  // target came from the cache
        end
      end
      default: begin
        next_istate = IF_IDLE;
      end
    endcase
    if (fatal) begin
      next_istate = IF_IDLE;
    end
  end

  // request to the system bus: data first, fetch waits for it
  wire want_d = (next_dstate == D_WAIT) & (istate != IF_FILL);
  wire want_i = (next_istate == IF_WAIT) & (next_dstate == D_IDLE) & (dstate == D_IDLE);
  wire i_open = (istate == IF_IDLE) | (istate == IF_TARGET);  // fetch flavour still taken from the pins
  wire d_write_now = (dstate == D_IDLE) ? store_start : d_write;  // flavour before it is latched
  wire pmec_pkg::pmec_bus_kind_type next_kind = want_d ? (d_write_now ? pmec_pkg::PMEC_BUS_DWRITE :
                                                 pmec_pkg::PMEC_BUS_DREAD) : pmec_pkg::PMEC_BUS_IFETCH;
  wire next_abort = fatal & ((dstate == D_FILL) | (istate == IF_FILL));

  // interlocks seen by the instruction entering execute next cycle
  wire dep_rs = dec_in.rs == load_dest;
  wire dep_rt = dec_in.rt == load_dest;
  wire data_owed = load_pending & ~beat_d & (load_dest != `PMEC_REG_ZERO);
  wire next_dep_stall = dec_in.valid & data_owed & (dep_rs | dep_rt);
  wire next_mem_stall = dec_in.valid & dec_in.is_mem & (next_dstate != D_IDLE);
  wire next_stall_fetch = (next_istate == IF_WAIT) | (next_istate == IF_TARGET) |
                          ((next_istate == IF_FILL) & ~stream_mode);

  // state registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      istate <= IF_IDLE;
      dstate <= D_IDLE;
    end else begin
      istate <= next_istate;
      dstate <= next_dstate;
    end
  end

  // fill bookkeeping: mode, stream stop, access flavour
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stream_mode <= '0;
      cut <= '0;
      i_uncached <= '0;
      d_uncached <= '0;
      d_write <= '0;
    end else begin
      if (grant_i) begin
        stream_mode <= ~wide_sync;
      end
      if (stop_now | (take & (istate != IF_IDLE))) begin
        cut <= '1;  // an exception in the grant cycle still wins
      end else if (grant_i | (next_istate == IF_IDLE)) begin
        cut <= '0;
      end
      if (i_open) begin
        i_uncached <= fetch_in.uncached;
      end
      if (d_start & (dstate == D_IDLE)) begin
        d_uncached <= mem_in.uncached;
        d_write <= store_start;
      end
    end
  end

  // missed load tracking, cleared by the first delivered word
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      load_pending <= '0;
      load_dest <= `PMEC_REG_ZERO;
    end else if (fatal | beat_d) begin
      load_pending <= '0;
    end else if (load_start & ~take & (dstate == D_IDLE)) begin
      load_pending <= '1;
      load_dest <= mem_in.dest;
    end
  end

  // buffer pointers: up to two writes a beat, one read a cycle
  wire [PW-1:0] wr_step = bus_in.two ? PW'(2) : PW'(1);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (grant_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (beat_i) begin
        wr_ptr <= wr_ptr + wr_step;
      end
      if (can_issue) begin
        rd_ptr <= rd_ptr + PW'(1);
      end
    end
  end

  // one write port pair per buffer entry
  for (genvar i = 0; i < LINE_INSTR; i++) begin : g_line
    wire hit_lo = beat_i & (wr_ptr[IW-1:0] == IW'(i));
    wire hit_hi = beat_i & bus_in.two & ((wr_ptr[IW-1:0] + IW'(1)) == IW'(i));
    always_ff @(posedge ref_clk) begin
      if (hit_lo) begin
        line_mem[i] <= bus_in.data[`PMEC_INSTR_W-1:0];
      end else if (hit_hi) begin
        line_mem[i] <= bus_in.data[`PMEC_HI_LANE +: `PMEC_INSTR_W];
      end
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_out <= '0;
      issue <= '0;
      stall_fetch <= '0;
      stall_exec <= '0;
      flush <= '0;
      div_kill <= '0;
    end else begin
      bus_out.req <= (want_d | want_i) & ~fatal;
      bus_out.kind <= next_kind;
      bus_out.uncached <= want_d ? d_uncached | mem_in.uncached : (i_open ? fetch_in.uncached : i_uncached);
      bus_out.abort <= next_abort;
      issue.valid <= can_issue;
      issue.instr <= line_mem[rd_ptr[IW-1:0]];
      stall_fetch <= next_stall_fetch;
      stall_exec <= next_dep_stall | next_mem_stall;
      flush.abort_e <= take;
      flush.abort_m <= exc_m | fatal;
      flush.redirect <= take;
      flush.vec <= next_vec;
      div_kill <= fatal & div_busy;
    end
  end

  // checks of the behaviour above
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_fetch_miss;
    (istate == IF_IDLE) & fetch_start & ~take;
  endsequence
  sequence s_data_idle;
    (dstate == D_IDLE) & ~d_start;
  endsequence

  a_fetch_miss_req: assert property (s_fetch_miss ##0 s_data_idle |=> bus_out.req)
    else $error("fetch miss did not raise a bus request");
  a_dload_miss_req: assert property ((dstate == D_IDLE) & d_start & (istate != IF_FILL)
                                     |=> bus_out.req & (bus_out.kind != pmec_pkg::PMEC_BUS_IFETCH))
    else $error("data miss did not raise a bus request");
  a_single_issue: assert property (issue.valid |-> $past(rd_ptr) != $past(wr_ptr))
    else $error("issue without a buffered instruction");
  a_no_stream_wide: assert property (issue.valid & ($past(istate) == IF_FILL) |-> $past(stream_mode))
    else $error("instruction issued mid refill with streaming off");
  a_cut_no_issue: assert property ((cut | stop_now) |=> ~issue.valid)
    else $error("instruction issued after streaming stopped");
  a_target_stall: assert property ((istate == IF_TARGET) ##1 (istate == IF_TARGET) |-> stall_fetch)
    else $error("fetch not stalled while awaiting branch target");
  a_dep_stall: assert property (dec_in.valid & data_owed & dep_rs |=> stall_exec)
    else $error("dependent instruction not stalled");
  a_mem_interlock: assert property (dec_in.valid & dec_in.is_mem & (dstate == D_FILL) & ~last_d & ~fatal
                                    |=> stall_exec)
    else $error("memory access not interlocked during refill");
  a_fetch_waits: assert property ((dstate != D_IDLE) |=> ~(bus_out.req & bus_out.kind == pmec_pkg::PMEC_BUS_IFETCH)
                                  or (dstate == D_IDLE))
    else $error("fetch refill requested during data refill");
  a_exc_flush: assert property (take |=> flush.abort_e & flush.redirect)
    else $error("exception did not abort and redirect");
  a_e_stage_vec: assert property (exc_e & ~exc_m & ~fatal |=> flush.vec == pmec_pkg::PMEC_VEC_ESTAGE
                                  & ~flush.abort_m)
    else $error("execute stage exception misclassified");
  a_reset_any: assert property (soft_reset_req |=> flush.abort_m & flush.vec == pmec_pkg::PMEC_VEC_RESET)
    else $error("soft reset not taken");
  a_refill_kept: assert property ((dstate == D_FILL) & (exc_m | exc_e) & ~fatal & ~last_d
                                  |=> dstate == D_FILL)
    else $error("data refill dropped by non-fatal exception");
  a_fatal_abort: assert property ((dstate == D_FILL) & fatal |=> bus_out.abort ##0 (dstate == D_IDLE))
    else $error("fatal exception did not abort refill");
  a_div_survives: assert property (div_busy & ~fatal |=> ~div_kill)
    else $error("divide killed by non-fatal event");
  a_nonblock_load: assert property (load_pending & dec_in.valid & ~dec_in.is_mem & ~dep_rs & ~dep_rt
                                    & (dstate == D_FILL) |=> ~stall_exec)
    else $error("independent instruction stalled by a load miss");

endmodule : pmec_pipe_ctrl

/* design/pmec_pkg.sv */
// shared types of the miss and exception control block
package pmec_pkg;
  `include "pmec_map.svh"
  typedef enum logic [1:0] {PMEC_BUS_IFETCH, PMEC_BUS_DREAD, PMEC_BUS_DWRITE} pmec_bus_kind_type;
  typedef enum logic [1:0] {PMEC_VEC_RESET, PMEC_VEC_BUSERR, PMEC_VEC_MSTAGE, PMEC_VEC_ESTAGE} pmec_vec_type;
  typedef struct packed {
    logic valid;
    logic miss;
    logic uncached;
  } pmec_fetch_type;
  typedef struct packed {
    logic valid;
    logic is_mem;
    logic [`PMEC_REG_W-1:0] rs;
    logic [`PMEC_REG_W-1:0] rt;
  } pmec_dec_type;
  typedef struct packed {
    logic valid;
    logic is_branch;
    logic debug_single_step_exc;
    logic debug_instr_break_exc;
    logic fetch_address_error_exc;
    logic fetch_translation_miss_exc;
  } pmec_exe_type;
  typedef struct packed {
    logic valid;
    logic is_load;
    logic is_store;
    logic dmiss;
    logic uncached;
    logic exc;
    logic [`PMEC_REG_W-1:0] dest;
  } pmec_mem_type;
  typedef struct packed {
    logic grant;
    logic beat;
    logic two;
    logic last;
    logic berr;
    logic [`PMEC_BUS_W-1:0] data;
  } pmec_bus_rsp_type;
  typedef struct packed {
    logic req;
    pmec_bus_kind_type kind;
    logic uncached;
    logic abort;
  } pmec_bus_req_type;
  typedef struct packed {
    logic valid;
    logic [`PMEC_INSTR_W-1:0] instr;
  } pmec_issue_type;
  typedef struct packed {
    logic abort_e;
    logic abort_m;
    logic redirect;
    pmec_vec_type vec;
  } pmec_flush_type;
endpackage : pmec_pkg

/* tb/pmec_bus_model.sv */
// far side model of the system bus: grants fill requests and returns beats
`timescale 1ns/1ps
module pmec_bus_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire pmec_pkg::pmec_bus_req_type bus_out,
  input wire logic [3:0] nbeats, // beats in one transfer
  input wire logic [3:0] gap, // idle cycles before each beat, for a slow bus
  input wire logic two, // each beat carries two instructions
  input wire logic inj_berr, // first beat flagged as bus error, on command only
  output pmec_pkg::pmec_bus_rsp_type bus_in
);
  logic killed; // set by reset or an abort pulse, ends the beats
  // one cycle; reset is seen at the edge, the one-cycle abort once it has settled
  task automatic step;
    @(posedge ref_clk);
    if (!resetn) killed = 1'h1;
    #1;
    if (bus_out.abort === 1'h1) killed = 1'h1;
  endtask : step
  // one transfer at a time; idle data flips so a stale word never looks valid
  initial begin
    bus_in = '0;
    killed = 1'h0;
    forever begin
      step;
      if (resetn && bus_out.req) begin
        killed = 1'h0;
        bus_in = {1'h1, 4'h0, ~bus_in.data};
        for (int i = 0; i < nbeats; i++) begin
          repeat (gap) begin
            step;
            bus_in = {5'h0, ~bus_in.data};
          end
          step;
          if (killed) begin
            bus_in = {5'h0, ~bus_in.data};
            break;
          end
          bus_in = {1'h0, 1'h1, two, i == nbeats - 1, inj_berr && i == 0, 64'(i)};
        end
      end else begin
        bus_in = {5'h0, ~bus_in.data};
      end
    end
  end
endmodule : pmec_bus_model

/* tb/tb_pmec_pipe_ctrl.sv */
// self-checking bench for the miss and exception control block
`timescale 1ns/1ps
module tb_pmec_pipe_ctrl;
  logic ref_clk;
  logic resetn;
  pmec_pkg::pmec_fetch_type fetch_in;
  pmec_pkg::pmec_dec_type dec_in;
  pmec_pkg::pmec_exe_type exe_in;
  pmec_pkg::pmec_mem_type mem_in;
  pmec_pkg::pmec_bus_rsp_type bus_in;
  pmec_pkg::pmec_bus_req_type bus_out;
  pmec_pkg::pmec_issue_type issue;
  pmec_pkg::pmec_flush_type flush;
  logic soft_reset_req, wide_bus_1to1, div_busy, stall_fetch, stall_exec, div_kill;
  logic [3:0] nbeats, gap; // bus model shape
  logic two, inj_berr;
  int failures, cmp_count;
  int n_iss, n_beat, n_last, n_abort, n_kill, n_berr, iss_last; // events seen at edges
  // short line of four so runs stay brief
  pmec_pipe_ctrl #(.LINE_INSTR(4)) i_pmec_pipe_ctrl (.ref_clk(ref_clk), .resetn(resetn),
    .fetch_in(fetch_in), .dec_in(dec_in), .exe_in(exe_in), .mem_in(mem_in), .bus_in(bus_in),
    .soft_reset_req(soft_reset_req), .wide_bus_1to1(wide_bus_1to1), .div_busy(div_busy),
    .bus_out(bus_out), .issue(issue), .stall_fetch(stall_fetch), .stall_exec(stall_exec),
    .flush(flush), .div_kill(div_kill));
  pmec_bus_model i_pmec_bus_model (.ref_clk(ref_clk), .resetn(resetn), .bus_out(bus_out),
    .nbeats(nbeats), .gap(gap), .two(two), .inj_berr(inj_berr), .bus_in(bus_in));
  // 20 ns period
  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end
  // count events at the sampling edge so tests never race the design
  always @(posedge ref_clk) begin
    if (issue.valid === 1'h1) n_iss++;
    if (bus_in.beat) n_beat++;
    if (bus_in.beat && bus_in.last) begin
      n_last++;
      iss_last = n_iss;
    end
    if (bus_in.berr) n_berr++;
    if (bus_out.abort === 1'h1) n_abort++;
    if (div_kill === 1'h1) n_kill++;
  end
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // bounded wait for an event counter; running out ends the run
  task automatic wait_cnt(ref int c, input int k);
    int t;
    t = 0;
    while (c < k && t < 300) begin
      tick;
      t++;
    end
    if (c < k) begin
      failures++;
      $display("unexpected event count expected %0d seen %0d", k, c);
      end_sim;
    end
  endtask : wait_cnt
  // a hit in fetch releases the branch target fetch hold
  task automatic hit;
    fetch_in = 3'h4;
    tick;
    fetch_in = '0;
    tick;
  endtask : hit
  task automatic t_fetch(input logic unc);
    int b, i0;
    b = n_last;
    i0 = n_iss;
    nbeats = unc ? 4'h1 : 4'h4;
    fetch_in = {1'h1, ~unc, unc};
    tick;
    fetch_in = '0;
    chk("fill request", 1'h1, bus_out.req);
    chk("fill kind", pmec_pkg::PMEC_BUS_IFETCH, bus_out.kind);
    chk("fill uncached", unc, bus_out.uncached);
    chk("fetch stall", 1'h1, stall_fetch);
    wait_cnt(n_last, b + 1);
    repeat (4) tick;
    chk("issued", nbeats, n_iss - i0);
    if (!unc) chk("issued before end", 1'h1, iss_last > i0);
    hit;
    $display("fetch test done");
  endtask : t_fetch
  task automatic t_wide;
    int b, i0;
    wide_bus_1to1 = 1'h1;
    two = 1'h1;
    nbeats = 4'h2;
    repeat (3) tick;
    b = n_last;
    i0 = n_iss;
    fetch_in = 3'h6;
    tick;
    fetch_in = '0;
    wait_cnt(n_last, b + 1);
    chk("issued during fill", 1'h0, iss_last - i0);
    repeat (6) tick;
    chk("issued", 4'h4, n_iss - i0);
    wide_bus_1to1 = 1'h0;
    two = 1'h0;
    hit;
    $display("wide test done");
  endtask : t_wide
  task automatic t_branch;
    int b, i0, i1;
    b = n_last;
    i0 = n_iss;
    nbeats = 4'h4;
    gap = 4'h1;
    fetch_in = 3'h6;
    tick;
    fetch_in = '0;
    wait_cnt(n_iss, i0 + 1);
    exe_in = 6'h30;
    tick;
    exe_in = '0;
    i1 = n_iss;
    wait_cnt(n_last, b + 1);
    repeat (3) tick;
    chk("issue after branch", i1, n_iss);
    chk("target stall", 1'h1, stall_fetch);
    hit;
    chk("target stall", 1'h0, stall_fetch);
    gap = 4'h0;
    $display("branch test done");
  endtask : t_branch
  task automatic t_data;
    int b, b1, t;
    b = n_last;
    b1 = n_beat;
    gap = 4'h2;
    mem_in = {6'h34, 5'h05};
    tick;
    mem_in = '0;
    chk("data request", 1'h1, bus_out.req);
    chk("data kind", pmec_pkg::PMEC_BUS_DREAD, bus_out.kind);
    dec_in = {2'h2, 5'h01, 5'h02};
    tick;
    chk("independent stall", 1'h0, stall_exec);
    dec_in = {2'h2, 5'h05, 5'h00};
    tick;
    chk("dependent stall", 1'h1, stall_exec);
    chk("beats before stall", 1'h0, n_beat - b1);
    t = 0;
    while (stall_exec === 1'h1 && t < 50) begin
      tick;
      t++;
    end
    chk("data at release", 2'h2, {n_beat > b1, stall_exec});
    dec_in = 12'hc00;
    tick;
    chk("memory op stall", 1'h1, stall_exec);
    dec_in = '0;
    wait_cnt(n_last, b + 1);
    tick;
    dec_in = 12'hc00;
    tick;
    chk("memory op stall", 1'h0, stall_exec);
    dec_in = '0;
    // uncached store: single beat, write kind
    nbeats = 4'h1;
    mem_in = {6'h2a, 5'h00};
    tick;
    mem_in = '0;
    chk("store kind", pmec_pkg::PMEC_BUS_DWRITE, bus_out.kind);
    chk("store uncached", 1'h1, bus_out.uncached);
    wait_cnt(n_last, b + 2);
    nbeats = 4'h4;
    $display("data test done");
  endtask : t_data
  task automatic t_both;
    int b, t, v;
    b = n_last;
    gap = 4'h1;
    v = 0;
    t = 0;
    mem_in = {6'h34, 5'h05};
    tick;
    mem_in = '0;
    fetch_in = 3'h6;
    tick;
    fetch_in = '0;
    while (n_last == b && t < 100) begin
      if (bus_out.req === 1'h1 && bus_out.kind === pmec_pkg::PMEC_BUS_IFETCH) v++;
      tick;
      t++;
    end
    chk("early fetch request", 1'h0, v);
    t = 0;
    while (bus_out.req !== 1'h1 && t < 8) begin
      tick;
      t++;
    end
    chk("fetch after data", {1'h1, pmec_pkg::PMEC_BUS_IFETCH}, {bus_out.req, bus_out.kind});
    wait_cnt(n_last, b + 2);
    hit;
    $display("fill order test done");
  endtask : t_both
  task automatic t_mexc;
    int b, a0, k0;
    b = n_last;
    a0 = n_abort;
    k0 = n_kill;
    div_busy = 1'h1;
    mem_in = {6'h34, 5'h05};
    dec_in = {2'h2, 5'h01, 5'h02};
    tick;
    mem_in = '0;
    tick;
    chk("divide side stall", 1'h0, stall_exec);
    mem_in = {6'h21, 5'h00};
    tick;
    mem_in = '0;
    chk("m flush", {3'h7, pmec_pkg::PMEC_VEC_MSTAGE}, flush);
    tick;
    chk("flush pulse", 3'h0, {flush.abort_e, flush.abort_m, flush.redirect});
    wait_cnt(n_last, b + 1);
    chk("refill abort", 1'h0, n_abort - a0);
    chk("divide kill", 1'h0, n_kill - k0);
    div_busy = 1'h0;
    dec_in = '0;
    $display("m stage test done");
  endtask : t_mexc
  task automatic t_eexc;
    // each of the four fetch and debug flags in turn
    for (int k = 0; k < 4; k++) begin
      exe_in = 6'h20 | (6'h08 >> k);
      tick;
      exe_in = '0;
      chk("e flush", {3'h5, pmec_pkg::PMEC_VEC_ESTAGE}, flush);
      tick;
    end
    soft_reset_req = 1'h1;
    exe_in = 6'h28;
    tick;
    soft_reset_req = 1'h0;
    exe_in = '0;
    chk("soft reset flush", {3'h7, pmec_pkg::PMEC_VEC_RESET}, flush);
    tick;
    $display("e stage test done");
  endtask : t_eexc
  task automatic t_fatal;
    int b, e0;
    b = n_last;
    e0 = n_berr;
    div_busy = 1'h1;
    inj_berr = 1'h1;
    mem_in = {6'h34, 5'h05};
    tick;
    mem_in = '0;
    wait_cnt(n_berr, e0 + 1);
    chk("fatal flush", {3'h7, pmec_pkg::PMEC_VEC_BUSERR}, flush);
    chk("fill abort", 1'h1, bus_out.abort);
    chk("divide kill", 1'h1, div_kill);
    inj_berr = 1'h0;
    div_busy = 1'h0;
    repeat (6) tick;
    chk("aborted fill end", 1'h0, n_last - b);
    // hard reset once a fetch refill has taken its bus grant, before any beat
    fetch_in = 3'h6;
    tick;
    fetch_in = '0;
    tick;
    resetn = 1'h0;
    tick;
    chk("outputs in reset", 8'h0, {bus_out.req, issue.valid, stall_fetch, flush});
    resetn = 1'h1;
    repeat (3) tick;
    $display("fatal test done");
  endtask : t_fatal
  initial begin
    resetn = 1'h0;
    fetch_in = '0;
    dec_in = '0;
    exe_in = '0;
    mem_in = '0;
    soft_reset_req = 1'h0;
    wide_bus_1to1 = 1'h0;
    div_busy = 1'h0;
    nbeats = 4'h4;
    gap = 4'h0;
    two = 1'h0;
    inj_berr = 1'h0;
    repeat (8) @(posedge ref_clk);
    #1 resetn = 1'h1;
    repeat (3) tick;
    t_fetch(1'h0);
    t_fetch(1'h1);
    t_wide;
    t_branch;
    t_data;
    t_both;
    t_mexc;
    t_eexc;
    t_fatal;
    end_sim;
  end
endmodule : tb_pmec_pipe_ctrl
